// [src/mdr_pkg.sv]
// Constants for the channel data register bank.
// Assumes one 10 MHz clock and a synchronous active-high reset.
package mdr_pkg;

    // Channel organisation
    localparam int CHANNELS = 40;
    localparam int GROUPS = 5;
    localparam int GROUP_SIZE = 8;
    localparam int CHAN_W = 6;
    localparam int DATA_W = 16;
    localparam int LEVEL_W = 14;

    // Reference input used by each group, one bit per group
    localparam logic [4:0] GROUP_REF_SECOND = 5'h1E;

    // Register type codes on the write port
    localparam logic [2:0] TYPE_INPUT = 3'h0;
    localparam logic [2:0] TYPE_GAIN = 3'h1;
    localparam logic [2:0] TYPE_OFFSET = 3'h2;
    localparam logic [2:0] TYPE_LEVEL0 = 3'h3;
    localparam logic [2:0] TYPE_LEVEL1 = 3'h4;
    localparam logic [2:0] TYPE_CONTROL = 3'h5;
    localparam logic [2:0] TYPE_BANK_SEL = 3'h6;

    // Lanes of the per-channel memory word
    localparam int LANE_FIRST = 0;
    localparam int LANE_SECOND = 1;
    localparam int LANE_GAIN = 2;
    localparam int LANE_OFFSET = 3;
    localparam int LANES = 4;

    // Reset values
    localparam logic [15:0] INPUT_RESET = 16'h1555;
    localparam logic [15:0] GAIN_RESET = 16'h3FFF;
    localparam logic [15:0] OFFSET_RESET = 16'h2000;
    localparam logic [13:0] LEVEL_RESET = 14'h1555;
    localparam logic [2:0] CONTROL_RESET = 3'h0;
    localparam logic [7:0] BANK_SEL_RESET = 8'h00;
    localparam logic [15:0] CAL_RESET = 16'h0000;
    localparam logic [63:0] CHAN_WORD_RESET =
        {OFFSET_RESET, GAIN_RESET, INPUT_RESET, INPUT_RESET};

    // Control register fields
    localparam int CTRL_SECOND_BANK = 2;
    localparam int CTRL_THERMAL_EN = 1;
    localparam int CTRL_POWER_DOWN = 0;

    // Calibration arithmetic
    localparam int CAL_W = 19;
    localparam logic signed [18:0] CAL_MID = 19'sh08000;
    localparam logic signed [18:0] CAL_MAX = 19'sh0FFFF;

    // Calibration engine states
    typedef enum logic [2:0] {
        CAL_IDLE = 3'b001,
        CAL_FETCH = 3'b010,
        CAL_STORE = 3'b100
    } mdr_cal_state_type;

endpackage

// [src/mdr_chan_mem.sv]
// Per-channel word store with lane-masked writes and a registered read.
// Assumes the caller never reads and writes the same entry in one cycle.
`timescale 1ns/1ps
module mdr_chan_mem #(
    parameter int DEPTH = 40,
    parameter int AW = 6,
    parameter int LANE_W = 16,
    parameter int LANES = 4,
    parameter logic [LANES*LANE_W-1:0] RESET_WORD = '0
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wr_en_i,
    input wire logic [AW-1:0] wr_addr_i,
    input wire logic [LANES-1:0] wr_lane_i,
    input wire logic [LANE_W-1:0] wr_data_i,
    input wire logic rd_en_i,
    input wire logic [AW-1:0] rd_addr_i,
    output logic [LANES*LANE_W-1:0] rd_data_o
);

    logic [LANES*LANE_W-1:0] store [DEPTH];

    // Flops rather than RAM: every entry needs its reset value
    genvar e;
    genvar l;
    generate
        for (e = 0; e < DEPTH; e++)
        begin : g_entry
            for (l = 0; l < LANES; l++)
            begin : g_lane
                always_ff @(posedge clock_i)
                begin
                    if (rst_i)
                        store[e][l*LANE_W +: LANE_W] <=
                            RESET_WORD[l*LANE_W +: LANE_W];
                    else if (wr_en_i && wr_lane_i[l] &&
                             wr_addr_i == AW'(e))
                        store[e][l*LANE_W +: LANE_W] <= wr_data_i;
                end
            end
        end
    endgenerate

    // Registered read port
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            rd_data_o <= '0;
        else if (rd_en_i)
            rd_data_o <= store[rd_addr_i];
    end

endmodule // mdr_chan_mem

// [src/mdr_bank.sv]
// Data register bank of a 40-channel converter: trims, calibration,
// bank selection and the simultaneous load of the converter codes.
// Assumes a decoded write port in front of it and one clock domain.
//
// Operation
// RULE1: Forty channels in five groups; group 0 on first reference.
// RULE2: Each channel has a first input register, reset 0x1555.
// RULE3: Second input register, reset 0x1555, written when bank bit set.
// RULE4: Each channel has a gain trim register, reset 0x3FFF.
// RULE5: Each channel has an offset trim register, reset 0x2000.
// RULE6: Two hidden calibrated registers per channel, one per bank.
// RULE7: Final converter register loads only from a calibrated register.
// RULE8: Final converter register code drives the channel's converter.
// RULE9: Group 0 offset level register, 14 bits, reset 0x1555.
// RULE10: Groups 1 to 4 offset level register, 14 bits, reset 0x1555.
// RULE11: Control register resets to zero; bit 2 picks input bank.
// RULE12: Control bit 1 enables thermal shutdown.
// RULE13: Control bit 0 requests soft power-down.
// RULE14: Five bank select registers, one bit per channel, reset zero.
// RULE15: Input or trim writes recompute the calibrated register.
// RULE16: Code times gain plus one over 2^16, plus offset, less 2^15.
// RULE17: Load strobe low copies selected calibrated values everywhere.
// RULE18: Bank select bit n belongs to group channel n.
// RULE19: Calibrated result saturates to 0 through 65535.
// RULE20: Writes arrive as channel, type and value in one cycle.
`timescale 1ns/1ps
module mdr_bank (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wr_valid_i,
    output logic wr_ready_o,
    input wire logic [mdr_pkg::CHAN_W-1:0] wr_chan_i,
    input wire logic [2:0] wr_type_i,
    input wire logic [mdr_pkg::DATA_W-1:0] wr_data_i,
    input wire logic load_strobe_n_i,
    output logic [mdr_pkg::CHANNELS*mdr_pkg::DATA_W-1:0] dac_code_o,
    output logic [mdr_pkg::LEVEL_W-1:0] group0_offset_level_o,
    output logic [mdr_pkg::LEVEL_W-1:0] group1to4_offset_level_o,
    output logic [mdr_pkg::GROUPS*mdr_pkg::LEVEL_W-1:0] group_level_o,
    output logic [mdr_pkg::GROUPS-1:0] group_ref_second_o,
    output logic second_bank_o,
    output logic thermal_shutdown_en_o,
    output logic soft_power_down_o,
    output logic [mdr_pkg::CHANNELS-1:0] bank_select_o,
    output logic cal_busy_o
);
    import mdr_pkg::*;

    logic [2:0] global_control;
    logic [LEVEL_W-1:0] group0_offset_level;
    logic [LEVEL_W-1:0] group1to4_offset_level;
    logic [CHANNELS-1:0] bank_select;
    logic [DATA_W-1:0] cal_first [CHANNELS];
    logic [DATA_W-1:0] cal_second [CHANNELS];
    logic [DATA_W-1:0] dac_code [CHANNELS];
    mdr_cal_state_type cal_state;
    mdr_cal_state_type next_cal_state;
    logic [CHAN_W-1:0] cal_chan;
    logic cal_bank;
    logic [LANES*DATA_W-1:0] chan_word;
    logic [2:0] load_sync;
    logic load_active;

    // Write port type codes
    //   0 input data, bank picked by control bit 2
    //   1 gain trim, 2 offset trim
    //   3 group 0 level, 4 groups 1 to 4 level
    //   5 control, 6 bank select with the channel field as group
    //   7 and out-of-range channels are taken and then dropped
    // Dropping rather than stalling keeps the port free of error paths,
    // but a host typo in the channel field goes unnoticed.
    // Write decode; channels past the last one are dropped
    wire wr_take = wr_valid_i && wr_ready_o;
    wire chan_ok = wr_chan_i < CHAN_W'(CHANNELS);
    wire group_ok = wr_chan_i < CHAN_W'(GROUPS);
    wire wr_input = wr_take && chan_ok && wr_type_i == TYPE_INPUT;
    wire wr_gain = wr_take && chan_ok && wr_type_i == TYPE_GAIN;
    wire wr_offset = wr_take && chan_ok && wr_type_i == TYPE_OFFSET;
    wire wr_trim_any = wr_input || wr_gain || wr_offset;
    wire wr_level0 = wr_take && wr_type_i == TYPE_LEVEL0;
    wire wr_level1 = wr_take && wr_type_i == TYPE_LEVEL1;
    wire wr_control = wr_take && wr_type_i == TYPE_CONTROL;
    wire wr_bank_sel = wr_take && group_ok && wr_type_i == TYPE_BANK_SEL;
    wire bank_now = global_control[CTRL_SECOND_BANK]; // RULE11

    // Lane choice: input lands in the bank picked by the control bit
    wire [LANES-1:0] wr_lane = {wr_offset, wr_gain,
                                wr_input && bank_now,
                                wr_input && !bank_now}; // RULE3

    // No queue in front of the calibrator: a refused write must be held
    // by the host until ready returns.
    // Only one write is taken per calibration pass
    assign wr_ready_o = cal_state == CAL_IDLE; // RULE20
    assign cal_busy_o = cal_state != CAL_IDLE;

    // The store is read one cycle after the write lands, so the word
    // read back already holds the new lane; no bypass is needed.
    // Input and trim storage, one word per channel
    mdr_chan_mem #(
        .DEPTH(CHANNELS),
        .AW(CHAN_W),
        .LANE_W(DATA_W),
        .LANES(LANES),
        .RESET_WORD(CHAN_WORD_RESET) // RULE2 RULE4 RULE5
    ) u_chan_mem (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .wr_en_i(wr_trim_any),
        .wr_addr_i(wr_chan_i),
        .wr_lane_i(wr_lane),
        .wr_data_i(wr_data_i),
        .rd_en_i(cal_state == CAL_FETCH),
        .rd_addr_i(cal_chan),
        .rd_data_o(chan_word)
    );

    // Unused upper bits of the data word are ignored, never an error
    // Global registers
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            global_control <= CONTROL_RESET; // RULE11
            group0_offset_level <= LEVEL_RESET; // RULE9
            group1to4_offset_level <= LEVEL_RESET; // RULE10
        end
        else
        begin
            if (wr_control)
                global_control <= wr_data_i[2:0];
            if (wr_level0)
                group0_offset_level <= wr_data_i[LEVEL_W-1:0];
            if (wr_level1)
                group1to4_offset_level <= wr_data_i[LEVEL_W-1:0];
        end
    end

    // Bank select registers, bit n steering group channel n
    genvar g;
    generate
        for (g = 0; g < GROUPS; g++)
        begin : g_group
            always_ff @(posedge clock_i)
            begin
                if (rst_i)
                    bank_select[g*GROUP_SIZE +: GROUP_SIZE] <=
                        BANK_SEL_RESET; // RULE14
                else if (wr_bank_sel && wr_chan_i == CHAN_W'(g))
                    bank_select[g*GROUP_SIZE +: GROUP_SIZE] <=
                        wr_data_i[GROUP_SIZE-1:0]; // RULE18
            end
            // Group 0 has its own reference and level
            assign group_ref_second_o[g] = GROUP_REF_SECOND[g]; // RULE1
            assign group_level_o[g*LEVEL_W +: LEVEL_W] = (g == 0) ?
                group0_offset_level : group1to4_offset_level; // RULE1
        end
    endgenerate

    // Pass timing for a trim write taken at edge 0
    //   edge 0  value lands in the store, bank and channel latched
    //   edge 1  channel word read out of the store
    //   edge 2  clamped result lands in the hidden register
    //   edge 3  earliest edge for the next write
    // Trim writes are paced to one per three cycles; global writes
    // wait as well, since ready stays low for the whole pass.
    // Calibration sequencer: capture, fetch, store
    always_comb
    begin
        next_cal_state = cal_state;
        unique case (cal_state)
            CAL_IDLE:
                if (wr_trim_any)
                    next_cal_state = CAL_FETCH; // RULE15
            CAL_FETCH:
                next_cal_state = CAL_STORE;
            CAL_STORE:
                next_cal_state = CAL_IDLE;
            default:
                next_cal_state = CAL_IDLE;
        endcase
    end

    // Bank chosen when the write is taken, not when stored
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            cal_state <= CAL_IDLE;
            cal_chan <= '0;
            cal_bank <= 1'b0;
        end
        else
        begin
            cal_state <= next_cal_state;
            if (wr_trim_any)
            begin
                cal_chan <= wr_chan_i;
                cal_bank <= bank_now; // RULE15
            end
        end
    end

    // Widths: 16 by 17 bit product, top 17 bits kept after the shift.
    // The signed 19-bit sum spans -32768 to 98302, so nothing wraps
    // before the clamp; a narrower sum would fold large trims back
    // into range instead of saturating them.
    // One shared multiplier and adder for every channel
    wire [DATA_W-1:0] cal_input = cal_bank ?
        chan_word[LANE_SECOND*DATA_W +: DATA_W] :
        chan_word[LANE_FIRST*DATA_W +: DATA_W];
    wire [DATA_W:0] cal_gain_p1 =
        {1'b0, chan_word[LANE_GAIN*DATA_W +: DATA_W]} + 17'h00001;
    wire [DATA_W-1:0] cal_offset = chan_word[LANE_OFFSET*DATA_W +: DATA_W];
    wire [2*DATA_W:0] cal_product = cal_input * cal_gain_p1; // RULE16
    wire signed [CAL_W-1:0] cal_sum =
        $signed({2'b00, cal_product[2*DATA_W:DATA_W]}) +
        $signed({3'b000, cal_offset}) - CAL_MID; // RULE16

    // Clamp into the unsigned code range
    wire cal_low = cal_sum < 19'sh00000;
    wire cal_high = cal_sum > CAL_MAX;
    wire [DATA_W-1:0] cal_result = cal_low ? 16'h0000 :
        cal_high ? 16'hFFFF : cal_sum[DATA_W-1:0]; // RULE19
    wire cal_store = cal_state == CAL_STORE;

    // Latency: codes move four edges after the pin is first seen low.
    // A strobe pulse shorter than two clock periods may be missed.
    // Load strobe pin: three flops, act when the last two agree
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            load_sync <= 3'h7;
            load_active <= 1'b0;
        end
        else
        begin
            load_sync <= {load_sync[1:0], load_strobe_n_i};
            if (load_sync[1] == load_sync[2])
                load_active <= !load_sync[2];
        end
    end

    // Hidden calibrated registers and final converter registers
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++)
        begin : g_chan
            wire hit = cal_store && cal_chan == CHAN_W'(c);
            always_ff @(posedge clock_i)
            begin
                if (rst_i)
                begin
                    cal_first[c] <= CAL_RESET;
                    cal_second[c] <= CAL_RESET;
                end
                else if (hit)
                begin
                    // Only the engine writes these, never the host
                    if (cal_bank)
                        cal_second[c] <= cal_result; // RULE6
                    else
                        cal_first[c] <= cal_result; // RULE6
                end
            end

            // Trade-off: a write made while the strobe is low reaches
            // the converter without a second pulse, at the cost of codes
            // changing mid-strobe as the calibrator finishes.
            // Level-sensitive: codes follow while the strobe stays low
            always_ff @(posedge clock_i)
            begin
                if (rst_i)
                    dac_code[c] <= CAL_RESET;
                else if (load_active)
                    dac_code[c] <= bank_select[c] ?
                        cal_second[c] : cal_first[c]; // RULE7 RULE17
            end
            assign dac_code_o[c*DATA_W +: DATA_W] = dac_code[c]; // RULE8
        end
    endgenerate

    // The analog side reads these levels directly; they change at the
    // write edge, not at the load strobe.
    // Status and analog control outputs
    assign group0_offset_level_o = group0_offset_level;
    assign group1to4_offset_level_o = group1to4_offset_level;
    assign second_bank_o = bank_now;
    assign thermal_shutdown_en_o = global_control[CTRL_THERMAL_EN]; // RULE12
    assign soft_power_down_o = global_control[CTRL_POWER_DOWN]; // RULE13
    assign bank_select_o = bank_select;

endmodule // mdr_bank

// [dv/mdr_bank_monitor.sv]
// Checker for the channel data register bank.
// Bound to mdr_bank; sees only its ports, one clock domain.
`timescale 1ns/1ps
module mdr_bank_monitor (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic wr_valid_i,
    input wire logic wr_ready_o,
    input wire logic [mdr_pkg::CHAN_W-1:0] wr_chan_i,
    input wire logic [2:0] wr_type_i,
    input wire logic [mdr_pkg::DATA_W-1:0] wr_data_i,
    input wire logic load_strobe_n_i,
    input wire logic [mdr_pkg::CHANNELS*mdr_pkg::DATA_W-1:0] dac_code_o,
    input wire logic [mdr_pkg::LEVEL_W-1:0] group0_offset_level_o,
    input wire logic [mdr_pkg::LEVEL_W-1:0] group1to4_offset_level_o,
    input wire logic [mdr_pkg::GROUPS*mdr_pkg::LEVEL_W-1:0] group_level_o,
    input wire logic [mdr_pkg::GROUPS-1:0] group_ref_second_o,
    input wire logic second_bank_o,
    input wire logic thermal_shutdown_en_o,
    input wire logic soft_power_down_o,
    input wire logic [mdr_pkg::CHANNELS-1:0] bank_select_o,
    input wire logic cal_busy_o
);
    import mdr_pkg::*;
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);
    // Writes taken at this edge, by kind
    wire take = wr_valid_i && wr_ready_o;
    wire tk_in = take && wr_type_i == TYPE_INPUT &&
        wr_chan_i < CHAN_W'(CHANNELS);
    wire tk_ctl = take && wr_type_i == TYPE_CONTROL;
    wire tk_l0 = take && wr_type_i == TYPE_LEVEL0;
    wire tk_bs = take && wr_type_i == TYPE_BANK_SEL &&
        wr_chan_i < CHAN_W'(GROUPS);
    property p_busy;
        tk_in |=> !wr_ready_o [*2] ##1 wr_ready_o;
    endproperty
    a_busy: assert property (p_busy) else $error("busy span wrong");
    property p_pair;
        cal_busy_o == !wr_ready_o;
    endproperty
    a_pair: assert property (p_pair) else $error("busy not ready");
    property p_bank;
        tk_ctl |=> second_bank_o == $past(wr_data_i[2]);
    endproperty
    a_bank: assert property (p_bank) else $error("bank bit");
    property p_therm;
        tk_ctl |=> thermal_shutdown_en_o == $past(wr_data_i[1]);
    endproperty
    a_therm: assert property (p_therm) else $error("thermal bit");
    property p_power;
        tk_ctl |=> soft_power_down_o == $past(wr_data_i[0]);
    endproperty
    a_power: assert property (p_power) else $error("power bit");
    property p_lvl0;
        tk_l0 |=> group0_offset_level_o == $past(wr_data_i[13:0]);
    endproperty
    a_lvl0: assert property (p_lvl0) else $error("level 0");
    property p_glvl;
        group_level_o ==
            {{4{group1to4_offset_level_o}}, group0_offset_level_o};
    endproperty
    a_glvl: assert property (p_glvl) else $error("group level");
    property p_ref;
        group_ref_second_o == 5'h1E;
    endproperty
    a_ref: assert property (p_ref) else $error("reference map");
    // Strobe long high means the codes must sit still
    property p_hold;
        load_strobe_n_i [*6] |-> $stable(dac_code_o);
    endproperty
    a_hold: assert property (p_hold) else $error("code moved");
    property p_bsel;
        tk_bs |=> bank_select_o[$past(wr_chan_i)*8 +: 8]
            == $past(wr_data_i[7:0]);
    endproperty
    a_bsel: assert property (p_bsel) else $error("bank select");
    c_trim: cover property (tk_in);
    c_load: cover property ($fell(load_strobe_n_i));
    c_bsel: cover property (tk_bs);
endmodule // mdr_bank_monitor

// [dv/mdr_host.sv]
// Host model: writes decoded items and pulses the load strobe.
// Assumes the caller runs one task at a time.
`timescale 1ns/1ps
module mdr_host (
    input wire logic clock_i,
    input wire logic ready_i,
    output logic valid_o,
    output logic [5:0] chan_o,
    output logic [2:0] type_o,
    output logic [15:0] data_o,
    output logic load_n_o
);
    // Idle at time zero: no request, strobe inactive
    initial
    begin
        valid_o = 1'b0;
        chan_o = 6'h00;
        type_o = 3'h7;
        data_o = 16'h0000;
        load_n_o = 1'b1;
    end
    // Request held whole until ready is seen at an edge
    task write(input logic [5:0] c, input logic [2:0] t,
               input logic [15:0] d);
        @(posedge clock_i);
        valid_o <= 1'b1;
        chan_o <= c;
        type_o <= t;
        data_o <= d;
        do
            @(posedge clock_i);
        while (ready_i !== 1'b1);
        valid_o <= 1'b0;
        chan_o <= ~c; // Released channel and data lines never keep stale values
        data_o <= ~d;
    endtask
    // Low long enough to pass the synchronizer, then settle
    task load;
        @(posedge clock_i);
        load_n_o <= 1'b0;
        repeat (8) @(posedge clock_i);
        load_n_o <= 1'b1;
        repeat (8) @(posedge clock_i);
    endtask
endmodule // mdr_host

// [dv/mdr_bank_tb.sv]
// Testbench: host writes, loads, and compares against a model.
// Assumes mdr_pkg, mdr_bank, mdr_host and the monitor are compiled.
`timescale 1ns/1ps
bind mdr_bank mdr_bank_monitor u_mon (.clock_i(clock_i), .rst_i(rst_i),
    .wr_valid_i(wr_valid_i), .wr_ready_o(wr_ready_o),
    .wr_chan_i(wr_chan_i), .wr_type_i(wr_type_i), .wr_data_i(wr_data_i),
    .load_strobe_n_i(load_strobe_n_i), .dac_code_o(dac_code_o),
    .group0_offset_level_o(group0_offset_level_o),
    .group1to4_offset_level_o(group1to4_offset_level_o),
    .group_level_o(group_level_o), .group_ref_second_o(group_ref_second_o),
    .second_bank_o(second_bank_o),
    .thermal_shutdown_en_o(thermal_shutdown_en_o),
    .soft_power_down_o(soft_power_down_o), .bank_select_o(bank_select_o),
    .cal_busy_o(cal_busy_o));
module mdr_bank_tb;
    import mdr_pkg::*;
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic wr_valid, wr_ready, ld_n, sb, te, pd;
    logic [5:0] wr_chan;
    logic [2:0] wr_type;
    logic [15:0] wr_data;
    logic [639:0] dac_code;
    logic [13:0] lvl0, lvl1;
    logic [69:0] glvl;
    logic [4:0] ref2;
    logic [39:0] bsel, msel;
    logic [15:0] mi [2][40];
    logic [15:0] mc [2][40];
    logic [15:0] mg [40];
    logic [15:0] mo [40];
    logic mbank;
    int error_cnt = 0;
    int compares = 0;
    // Items: channel, type, value; type F means load and compare
    localparam logic [27:0] ITEMS [29] = '{
        28'h02_1_FFFF, 28'h02_2_8000, 28'h03_2_FFFF, 28'h04_0_FFFF,
        28'h04_1_FFFF, 28'h00_0_FFFF, 28'h00_1_FFFF, 28'h00_2_8000,
        28'h07_0_FFFF, 28'h07_1_FFFF, 28'h07_2_FFFF, 28'h27_1_7FFF,
        28'h27_2_8000, 28'h27_0_8000, 28'h08_0_1234, 28'h00_F_0000,
        28'h00_5_0004, 28'h27_0_2000, 28'h00_1_7FFF, 28'h02_1_FFFF,
        28'h04_6_0080, 28'h00_6_0005, 28'h00_7_FFFF, 28'h05_6_00FF,
        28'h28_0_FFFF, 28'h00_F_0000, 28'h00_5_0000, 28'h04_6_0000,
        28'h00_F_0000};
    // 10 MHz clock
    always #50 clock_i = ~clock_i;
    mdr_bank dut (.clock_i(clock_i), .rst_i(rst_i), .wr_valid_i(wr_valid),
        .wr_ready_o(wr_ready), .wr_chan_i(wr_chan), .wr_type_i(wr_type),
        .wr_data_i(wr_data), .load_strobe_n_i(ld_n), .dac_code_o(dac_code),
        .group0_offset_level_o(lvl0), .group1to4_offset_level_o(lvl1),
        .group_level_o(glvl), .group_ref_second_o(ref2),
        .second_bank_o(sb), .thermal_shutdown_en_o(te),
        .soft_power_down_o(pd), .bank_select_o(bsel), .cal_busy_o());
    mdr_host u_host (.clock_i(clock_i), .ready_i(wr_ready),
        .valid_o(wr_valid), .chan_o(wr_chan), .type_o(wr_type),
        .data_o(wr_data), .load_n_o(ld_n));
    task check(input logic [39:0] seen, input logic [39:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    // Saturating trim arithmetic, kept wide to see the overflow
    function automatic logic [15:0] cal(input logic [15:0] x, g, o);
        longint t;
        t = ((longint'(x) * (longint'(g) + 1)) >> 16) + o - 32768;
        if (t < 0) return 16'h0000;
        if (t > 65535) return 16'hFFFF;
        return t[15:0];
    endfunction
    // Write through the host and track the expected state
    task wr(input logic [5:0] c, input logic [2:0] t, input logic [15:0] d);
        u_host.write(c, t, d);
        if (t == 3'h6 && c < 5) msel[c*8 +: 8] = d[7:0];
        if (t <= 3'h2 && c < 40)
        begin
            if (t == 3'h0) mi[mbank][c] = d;
            if (t == 3'h1) mg[c] = d;
            if (t == 3'h2) mo[c] = d;
            mc[mbank][c] = cal(mi[mbank][c], mg[c], mo[c]);
        end
        if (t == 3'h5) mbank = d[2];
    endtask
    task load_check;
        u_host.load();
        check(bsel, msel);
        for (int c = 0; c < 40; c++)
            check(dac_code[16*c +: 16], mc[msel[c]][c]);
    endtask
    task tally_and_finish;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Watchdog well beyond the expected few hundred cycles
    initial
    begin
        repeat (6000) @(posedge clock_i);
        error_cnt++;
        tally_and_finish();
    end
    // Main sequence
    initial
    begin
        mbank = 1'b0;
        msel = 40'h0;
        for (int c = 0; c < 40; c++)
        begin
            mi[0][c] = 16'h1555;
            mi[1][c] = 16'h1555;
            mg[c] = 16'h3FFF;
            mo[c] = 16'h2000;
            mc[0][c] = 16'h0000;
            mc[1][c] = 16'h0000;
        end
        repeat (12) @(posedge clock_i);
        rst_i <= 1'b0;
        @(negedge clock_i);
        check(lvl0, 14'h1555);
        check(lvl1, 14'h1555);
        check({sb, te, pd}, 3'h0);
        check(ref2, 5'h1E);
        load_check();
        for (int b = 0; b < 3; b++)
        begin
            wr(6'h00, 3'h5, 16'h0001 << b);
            @(negedge clock_i);
            check({sb, te, pd}, 3'h1 << b);
        end
        wr(6'h00, 3'h5, 16'h0000);
        wr(6'h00, 3'h3, 16'hFABC);
        wr(6'h00, 3'h4, 16'h0123);
        @(negedge clock_i);
        check(glvl[13:0], 14'h3ABC);
        check(glvl[69:56], 14'h0123);
        foreach (ITEMS[i])
            if (ITEMS[i][19:16] == 4'hF) load_check();
            else wr(ITEMS[i][25:20], ITEMS[i][18:16], ITEMS[i][15:0]);
        wr(6'h00, 3'h5, 16'h0007);
        wr(6'h01, 3'h6, 16'h00FF);
        rst_i <= 1'b1;
        repeat (2) @(posedge clock_i);
        rst_i <= 1'b0;
        @(negedge clock_i);
        check({sb, te, pd}, 3'h0);
        check(bsel, 40'h0);
        tally_and_finish();
    end
endmodule // mdr_bank_tb
